// >>> pkg/fpb_pkg.sv
// constants and types for the flash page and burst read port
//
// Function
// - after reset the port reads in asynchronous page mode, no command needed
// - page reads happen only while read_config bit 15 is one
// - page mode senses one eight-word group, latching upper address bits
// - low three address bits pick page words, any order, repeatedly
// - upper address change or chip enable toggle reloads the page
// - register information loads a single word in either mode
// - burst address latched at addr_valid_n rise or first active clock edge
// - after latency, words leave on successive active edges, linear order
// - bursts are 8 or 16 words; deasserting enables ends them early
// - register information in burst mode stays driven for the access
// - read_config written by command, its contents are readable
// - bit 15 zero selects burst reads, one selects page reads
// - bits 14:11 latency count, codes 2 to 10 valid
// - bit 10 wait polarity, one means active high
// - bit 9 data hold, one holds each word two clocks
// - bit 8 wait delay, one releases wait a clock early
// - bit 7 burst order, only linear supported
// - bit 6 clock edge, one is rising; bits 5:3 stay zero
// - bits 2:0 burst length, 010 eight words, 011 sixteen words
package fpb_pkg;
    // ---------------------------------------------------------------
    // read configuration layout
    // ---------------------------------------------------------------
    localparam logic [15:0] CFG_RESET   = 16'hFFC7;
    localparam int          MODE_BIT    = 15;
    localparam int          LAT_MSB     = 14;
    localparam int          LAT_LSB     = 11;
    localparam int          WP_BIT      = 10;
    localparam int          HOLD_BIT    = 9;
    localparam int          WDLY_BIT    = 8;
    localparam int          BO_BIT      = 7;
    localparam int          CE_BIT      = 6;
    localparam int          RSV_MSB     = 5;
    localparam int          RSV_LSB     = 3;
    localparam int          LEN_MSB     = 2;
    localparam logic [2:0]  LEN_16      = 3'h3;
    localparam logic [3:0]  LAT_MIN     = 4'h2;
    localparam logic [3:0]  LAT_MAX     = 4'hA;
    // ---------------------------------------------------------------
    // buffer sizes and masks
    // ---------------------------------------------------------------
    localparam logic [4:0]  PAGE_WORDS  = 5'h08;
    localparam logic [4:0]  BURST_MAX   = 5'h10;
    localparam logic [4:0]  ONE_WORD    = 5'h01;
    localparam logic [3:0]  MASK_8      = 4'h7;
    localparam logic [3:0]  MASK_16     = 4'hF;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_SENSE = 5'h02,
        ST_PAGE  = 5'h04,
        ST_LATCH = 5'h08,
        ST_BURST = 5'h10
    } fpb_state_type;
endpackage

// >>> rtl/fpb_read_port.sv
// flash read path: async page reads and clocked burst reads
module fpb_read_port import fpb_pkg::*; #(
    parameter int ADDR_W = 23
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr_pin,
    input  wire logic              chip_en_n,
    input  wire logic              out_en_n,
    input  wire logic              write_en_n,
    input  wire logic              addr_valid_n,
    input  wire logic              burst_clk,
    input  wire logic              cfg_wr,
    input  wire logic [15:0]       cfg_data,
    input  wire logic              reg_space,
    input  wire logic              arr_rd_valid,
    input  wire logic [15:0]       arr_rd_data,
    output logic                   arr_rd_req,
    output logic [ADDR_W-1:0]      arr_addr,
    output logic [15:0]            data_out,
    output logic                   data_oe_n,
    output logic                   wait_out,
    output logic [15:0]            read_config
);
    if (ADDR_W < 5) begin : g_bad_width
        $error("fpb_read_port: ADDR_W must be at least 5");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam int SW = ADDR_W + 5;
    logic [SW-1:0] s1_reg, s2_reg;
    logic          clk3_reg;
    // first stage feeds only the second; clk3 is for edge finding
    always_ff @(posedge ref_clk) begin
        s1_reg   <= {addr_pin, chip_en_n, out_en_n, write_en_n,
                     addr_valid_n, burst_clk};
        s2_reg   <= s1_reg;
        clk3_reg <= s2_reg[0];
    end

    logic [ADDR_W-1:0] a_s;
    logic ce_act, oe_act, we_idle, adv_s, clk_s;
    assign a_s     = s2_reg[SW-1:5];
    assign ce_act  = ~s2_reg[4];
    assign oe_act  = ~s2_reg[3];
    assign we_idle = s2_reg[2];
    assign adv_s   = s2_reg[1];
    assign clk_s   = s2_reg[0];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    fpb_state_type     state_reg, state_next;
    logic [15:0]       cfg_reg, cfg_next;
    logic [15:0]       buf_reg [BURST_MAX], buf_next [BURST_MAX];
    logic [4:0]        ld_idx_reg, ld_idx_next, ld_tot_reg, ld_tot_next;
    logic [ADDR_W-1:0] ld_start_reg, ld_start_next;
    logic [3:0]        ld_mask_reg, ld_mask_next;
    logic [3:0]        cnt_reg, cnt_next;
    logic [3:0]        widx_reg, widx_next;
    logic              hold_reg, hold_next, on_reg, on_next;
    logic              wact_reg, wact_next, adv_d_reg, adv_d_next;
    logic [15:0]       dout_reg, dout_next;
    logic              doe_n_reg, doe_n_next, wpin_reg, wpin_next;

    logic       act_edge, burst_sel, start_ld;
    logic [3:0] lat, cnt_inc, wlast;
    logic [4:0] sel;

    // active edge chosen by the clock-edge bit
    assign act_edge = cfg_reg[CE_BIT] ? (clk_s & ~clk3_reg)
                                      : (~clk_s & clk3_reg);
    assign burst_sel = ~cfg_reg[MODE_BIT];
    // reserved latency codes are clamped so counters stay sane
    assign lat = (cfg_reg[LAT_MSB:LAT_LSB] < LAT_MIN) ? LAT_MIN :
                 (cfg_reg[LAT_MSB:LAT_LSB] > LAT_MAX) ? LAT_MAX :
                 cfg_reg[LAT_MSB:LAT_LSB];
    assign cnt_inc = (cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1;
    // reserved length codes fall back to eight words
    assign wlast = (cfg_reg[LEN_MSB:0] == LEN_16) ? MASK_16
                                                : MASK_8;
    assign sel = reg_space ? 5'h00 : {2'h0, a_s[2:0]};

    // loader asks the array one word at a time
    assign arr_rd_req = ld_idx_reg < ld_tot_reg;
    assign arr_addr   = (ld_start_reg & ~ADDR_W'(ld_mask_reg))
                      | ((ld_start_reg + ADDR_W'(ld_idx_reg))
                         & ADDR_W'(ld_mask_reg));

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        cfg_next      = cfg_reg;
        buf_next      = buf_reg;
        ld_idx_next   = ld_idx_reg;
        ld_tot_next   = ld_tot_reg;
        ld_start_next = ld_start_reg;
        ld_mask_next  = ld_mask_reg;
        cnt_next      = cnt_reg;
        widx_next     = widx_reg;
        hold_next     = hold_reg;
        on_next       = on_reg;
        wact_next     = wact_reg;
        adv_d_next    = adv_s;
        dout_next     = dout_reg;
        doe_n_next    = 1'b1;
        start_ld      = 1'b0;

        // configuration command; reserved bits forced to zero
        if (cfg_wr) begin
            cfg_next = {cfg_data[15:RSV_MSB+1], 3'h0,
                        cfg_data[LEN_MSB:0]};
            cfg_next[BO_BIT] = 1'b1;
        end

        // store returned array words in load order
        if (arr_rd_req && arr_rd_valid) begin
            buf_next[ld_idx_reg[3:0]] = arr_rd_data;
            ld_idx_next = ld_idx_reg + 5'h01;
        end

        case (state_reg)
            ST_IDLE: begin
                wact_next = 1'b0;
                on_next   = 1'b0;
                // a fresh chip enable starts a new sense in page mode; burst mode waits for the address latch
                if (ce_act && we_idle) begin
                    if (burst_sel) begin
                        state_next = ST_LATCH;
                    end else begin
                        start_ld   = 1'b1;
                        state_next = ST_SENSE;
                    end
                end
            end
            ST_SENSE, ST_PAGE: begin
                if (!ce_act || burst_sel) begin
                    state_next = ST_IDLE;
                end else if (a_s[ADDR_W-1:3]
                             != ld_start_reg[ADDR_W-1:3]) begin
                    start_ld   = 1'b1;
                    state_next = ST_SENSE;
                end else begin
                    if (ld_idx_reg > sel) begin
                        state_next = ST_PAGE;
                        dout_next  = buf_reg[sel[3:0]];
                    end
                    doe_n_next = ~(oe_act && we_idle
                                   && ld_idx_reg > sel);
                end
            end
            ST_LATCH: begin
                // whichever comes first: adv rise or active edge
                if (!ce_act) begin
                    state_next = ST_IDLE;
                end else if ((adv_s && !adv_d_reg)
                             || (act_edge && !adv_s)) begin
                    start_ld   = 1'b1;
                    cnt_next   = 4'h0;
                    wact_next  = 1'b1;
                    state_next = ST_BURST;
                end
            end
            ST_BURST: begin
                if (!ce_act || !oe_act) begin
                    state_next = ST_IDLE;
                end else if (act_edge) begin
                    cnt_next = cnt_inc;
                    if (cnt_inc >= lat - {3'h0, cfg_reg[WDLY_BIT]})
                        wact_next = 1'b0;
                    if (!on_reg && cnt_inc == lat) begin
                        on_next   = 1'b1;
                        widx_next = 4'h0;
                        hold_next = 1'b0;
                        dout_next = buf_reg[0];
                    end else if (on_reg) begin
                        if (cfg_reg[HOLD_BIT] && !hold_reg) begin
                            hold_next = 1'b1;
                        end else begin
                            hold_next = 1'b0;
                            // register data and last word stay put
                            if (!reg_space && widx_reg < wlast) begin
                                widx_next = widx_reg + 4'h1;
                                dout_next = buf_reg[widx_reg + 4'h1];
                            end
                        end
                    end
                end
                doe_n_next = ~(on_next && we_idle);
            end
            default: state_next = ST_IDLE;
        endcase

        // sense setup shared by both modes
        if (start_ld) begin
            ld_idx_next = 5'h00;
            if (reg_space) begin
                ld_start_next = a_s;
                ld_mask_next  = 4'h0;
                ld_tot_next   = ONE_WORD;
            end else if (burst_sel) begin
                ld_start_next = a_s;
                ld_mask_next  = wlast;
                ld_tot_next   = (wlast == MASK_16) ? BURST_MAX
                                                   : PAGE_WORDS;
            end else begin
                ld_start_next = {a_s[ADDR_W-1:3], 3'h0};
                ld_mask_next  = MASK_8;
                ld_tot_next   = PAGE_WORDS;
            end
        end

        // next polarity used so the pin never lags a config write
        wpin_next = wact_next ? cfg_next[WP_BIT]
                              : ~cfg_next[WP_BIT];
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            cfg_reg      <= CFG_RESET;
            ld_idx_reg   <= 5'h00;
            ld_tot_reg   <= 5'h00;
            ld_start_reg <= '0;
            ld_mask_reg  <= 4'h0;
            cnt_reg      <= 4'h0;
            widx_reg     <= 4'h0;
            hold_reg     <= 1'b0;
            on_reg       <= 1'b0;
            wact_reg     <= 1'b0;
            adv_d_reg    <= 1'b1;
            dout_reg     <= 16'h0000;
            doe_n_reg    <= 1'b1;
            wpin_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cfg_reg      <= cfg_next;
            ld_idx_reg   <= ld_idx_next;
            ld_tot_reg   <= ld_tot_next;
            ld_start_reg <= ld_start_next;
            ld_mask_reg  <= ld_mask_next;
            cnt_reg      <= cnt_next;
            widx_reg     <= widx_next;
            hold_reg     <= hold_next;
            on_reg       <= on_next;
            wact_reg     <= wact_next;
            adv_d_reg    <= adv_d_next;
            dout_reg     <= dout_next;
            doe_n_reg    <= doe_n_next;
            wpin_reg     <= wpin_next;
        end
    end

    // buffer contents need no reset; loaded before use
    always_ff @(posedge ref_clk) begin
        buf_reg <= buf_next;
    end

    assign data_out    = dout_reg;
    assign data_oe_n   = doe_n_reg;
    assign wait_out    = wpin_reg;
    assign read_config = cfg_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_reset_page_mode: assert property (@(posedge ref_clk)
        $fell(rst) |-> cfg_reg == CFG_RESET && state_reg == ST_IDLE)
        else $error("reset did not restore page mode");

    chk_reserved_zero: assert property (@(posedge ref_clk)
        disable iff (rst) cfg_reg[RSV_MSB:RSV_LSB] == 3'h0)
        else $error("reserved config bits not zero");

    chk_page_needs_mode: assert property (@(posedge ref_clk)
        disable iff (rst) state_reg == ST_PAGE |-> cfg_reg[MODE_BIT])
        else $error("page read while burst mode selected");

    chk_page_eight: assert property (@(posedge ref_clk)
        disable iff (rst) start_ld && !burst_sel && !reg_space
        |=> ld_tot_reg == 5'h08 && ld_start_reg[2:0] == 3'h0)
        else $error("page sense is not eight aligned words");

    chk_reg_single: assert property (@(posedge ref_clk)
        disable iff (rst) start_ld && reg_space |=> ld_tot_reg == 5'h01)
        else $error("register read loaded more than one word");

    chk_upper_reload: assert property (@(posedge ref_clk)
        disable iff (rst) state_reg == ST_PAGE && ce_act && !burst_sel
        && a_s[ADDR_W-1:3] != ld_start_reg[ADDR_W-1:3]
        |=> state_reg == ST_SENSE && ld_idx_reg == 5'h00)
        else $error("upper address change did not reload page");

    chk_burst_sixteen: assert property (@(posedge ref_clk)
        disable iff (rst) start_ld && burst_sel && !reg_space
        && cfg_reg[LEN_MSB:0] == LEN_16 |=> ld_tot_reg == 5'h10)
        else $error("sixteen word burst not sensed");

    chk_first_word: assert property (@(posedge ref_clk)
        disable iff (rst) state_reg == ST_BURST && ce_act && oe_act
        && act_edge && !on_reg && cnt_inc == lat
        |=> on_reg && dout_reg == $past(buf_reg[0]) && !data_oe_n)
        else $error("first burst word not driven at latency");

    chk_wait_idle: assert property (@(posedge ref_clk)
        disable iff (rst) state_reg == ST_IDLE ##1 state_reg == ST_IDLE
        |-> wait_out == ~cfg_reg[WP_BIT])
        else $error("wait not at its inactive level when idle");
endmodule // fpb_read_port

// >>> bench/fpb_array_model.sv
// array stand-in answering the read port's word requests
module fpb_array_model import fpb_pkg::*; #(
    parameter int ADDR_W = 23
) (
    input  wire logic              ref_clk,
    input  wire logic              arr_rd_req,
    input  wire logic [ADDR_W-1:0] arr_addr,
    input  wire logic              slow,
    output logic                   arr_rd_valid,
    output logic [15:0]            arr_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // word answers
    // ---------------------------------------------------------------
    logic [1:0]  delay_reg = 2'h0;
    logic [15:0] last_reg  = 16'h0000;

    // slow mode stretches each word to four cycles to expose load gaps
    always_ff @(posedge ref_clk) begin
        if (!arr_rd_req || arr_rd_valid) begin
            delay_reg <= 2'h0;
        end else begin
            delay_reg <= delay_reg + 2'h1;
        end
        if (arr_rd_valid) begin
            last_reg <= arr_rd_data;
        end
    end

    // idle data shows the inverse of the last word, never a stale copy
    always_comb begin
        arr_rd_valid = arr_rd_req && (!slow || delay_reg == 2'h3);
        arr_rd_data  = arr_rd_valid ?
                       {arr_addr[7:0] ^ 8'h5A, arr_addr[15:8]} : ~last_reg;
    end
endmodule // fpb_array_model

// >>> bench/fpb_read_port_bench.sv
// self-checking bench for the flash page and burst read port
module fpb_read_port_bench import fpb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // stimulus, design and array model
    // ---------------------------------------------------------------
    logic        ref_clk = 1'b0, rst = 1'b1;
    logic [22:0] addr_pin = 23'h0;
    logic        chip_en_n = 1'b1, out_en_n = 1'b1, write_en_n = 1'b1;
    logic        addr_valid_n = 1'b0, burst_clk = 1'b1;
    logic        cfg_wr = 1'b0, reg_space = 1'b0, slow_mode = 1'b0;
    logic [15:0] cfg_data = 16'h0000, arr_rd_data, data_out, read_config;
    logic        arr_rd_valid, arr_rd_req, data_oe_n, wait_out;
    logic [22:0] arr_addr;
    int          num_errors = 0, checks_done = 0, taken = 0;

    always #2 ref_clk = ~ref_clk;

    // words sensed from the array, cleared by each page_read and burst_run
    always @(posedge ref_clk)
        if (arr_rd_req && arr_rd_valid) taken <= taken + 1;

    fpb_read_port #(.ADDR_W(23)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .addr_pin(addr_pin),
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .addr_valid_n(addr_valid_n), .burst_clk(burst_clk), .cfg_wr(cfg_wr),
        .cfg_data(cfg_data), .reg_space(reg_space),
        .arr_rd_valid(arr_rd_valid), .arr_rd_data(arr_rd_data),
        .arr_rd_req(arr_rd_req), .arr_addr(arr_addr), .data_out(data_out),
        .data_oe_n(data_oe_n), .wait_out(wait_out), .read_config(read_config));

    fpb_array_model #(.ADDR_W(23)) u_array (
        .ref_clk(ref_clk), .arr_rd_req(arr_rd_req), .arr_addr(arr_addr),
        .slow(slow_mode), .arr_rd_valid(arr_rd_valid),
        .arr_rd_data(arr_rd_data));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    function automatic logic [15:0] exp_word(input logic [22:0] a);
        return {a[7:0] ^ 8'h5A, a[15:8]};
    endfunction

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic write_cfg(input logic [15:0] v);
        @(posedge ref_clk);
        cfg_wr <= 1'b1;
        cfg_data <= v;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask

    // clock stands high between frames, address valid held low
    task automatic host_idle();
        @(posedge ref_clk);
        chip_en_n <= 1'b1;
        out_en_n <= 1'b1;
        addr_valid_n <= 1'b0;
        reg_space <= 1'b0;
        burst_clk <= 1'b1;
        tick(8);
        @(negedge ref_clk);
        check("bus released", 16'h1, {15'h0, data_oe_n});
    endtask

    task automatic wait_data();
        int n;
        n = 0;
        while (data_oe_n !== 1'b0 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check("data drive", 16'h0, {15'h0, data_oe_n});
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_defaults();
        @(negedge ref_clk);
        check("read_config", CFG_RESET, read_config);
        check("wait idle", 16'h0, {15'h0, wait_out});
        write_cfg(16'h0000);
        check("read_config", 16'h0080, read_config);
        write_cfg(16'hFFFF);
        check("read_config", 16'hFFC7, read_config);
        $display("defaults and config test done");
    endtask

    // start mid-page, hop low bits in any order, then move the page
    task automatic page_read(input logic [22:0] base, input bit slow,
                             input bit rs);
        logic [2:0] order [6] = '{3'h1, 3'h7, 3'h0, 3'h6, 3'h3, 3'h1};
        logic [22:0] pa;
        @(negedge ref_clk);
        taken = 0;
        @(posedge ref_clk);
        slow_mode <= slow;
        reg_space <= rs;
        addr_pin <= base | 23'h6;
        chip_en_n <= 1'b0;
        out_en_n <= 1'b0;
        wait_data();
        check("first word", exp_word(base | 23'h6), data_out);
        for (int i = 0; i < 6 && !rs; i++) begin
            @(posedge ref_clk);
            pa = base | 23'(order[i]);
            addr_pin <= pa;
            tick(6);
            @(negedge ref_clk);
            check("page word", exp_word(pa), data_out);
        end
        check("words sensed", rs ? 16'h1 : 16'h8, 16'(taken));
        taken = 0;
        @(posedge ref_clk);
        addr_pin <= base ^ 23'h000142;
        tick(60);
        @(negedge ref_clk);
        check("moved word", exp_word(base ^ 23'h000142), data_out);
        check("words resensed", rs ? 16'h1 : 16'h8, 16'(taken));
        host_idle();
        $display("page test done");
    endtask

    task automatic burst_run(input logic [15:0] cfg, input logic [22:0] st,
                             input bit adv, input bit rs, input int edges);
        int          lat_code, hold, len, k, idx;
        logic [22:0] mask, a;
        logic        w;
        lat_code = int'(cfg[14:11]);
        hold = cfg[9] ? 2 : 1;
        len = (cfg[2:0] == LEN_16) ? 16 : 8;
        mask = 23'(len - 1);
        k = adv ? 1 : 0;
        write_cfg(cfg);
        taken = 0;
        @(posedge ref_clk);
        addr_pin <= st;
        reg_space <= rs;
        chip_en_n <= 1'b0;
        out_en_n <= 1'b0;
        if (adv) begin
            tick(6);
            addr_valid_n <= 1'b1;
            tick(6);
        end
        while (k <= edges) begin
            @(posedge ref_clk);
            burst_clk <= ~burst_clk;
            tick(5);
            @(negedge ref_clk);
            if (burst_clk === cfg[6]) begin
                w = (k < lat_code - int'(cfg[8])) ? cfg[10] : ~cfg[10];
                check("wait level", 16'(w), 16'(wait_out));
                if (k >= lat_code) begin
                    idx = rs ? 0 : (k - lat_code) / hold;
                    idx = (idx >= len) ? len - 1 : idx;
                    a = (st & ~mask) | ((st + 23'(idx)) & mask);
                    // register words hold for the access
                    check("burst word", exp_word(a), data_out);
                end
                k++;
            end
        end
        host_idle();
        check("words sensed", 16'(rs ? 1 : len), 16'(taken));
        $display("burst test done");
    endtask

    task automatic test_bursts();
        logic [15:0] cfg [5] = '{16'h14C2, 16'h1B83, 16'h25C3, 16'h16C2,
                                 16'h57C2};
        logic [22:0] st [5] = '{23'h235, 23'h114E, 23'h3003, 23'h17, 23'h40};
        bit          adv [5] = '{0, 1, 0, 0, 1};
        bit          rs [5] = '{0, 0, 0, 1, 0};
        int          edges [5] = '{11, 36, 7, 8, 27};
        for (int i = 0; i < 5; i++) begin
            burst_run(cfg[i], st[i], adv[i], rs[i], edges[i]);
        end
    endtask

    // a second reset in mid-run returns the port to page reads
    task automatic test_rereset();
        @(posedge ref_clk);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(4);
        @(negedge ref_clk);
        check("read_config", CFG_RESET, read_config);
        page_read(23'h0200C0, 1'b0, 1'b0);
        $display("reset test done");
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(4);
        test_defaults();
        page_read(23'h012340, 1'b1, 1'b0);
        page_read(23'h012340, 1'b0, 1'b0);
        page_read(23'h000888, 1'b0, 1'b1);
        test_bursts();
        test_rereset();
        results();
    end

    // whole run needs under ten thousand cycles
    initial begin
        tick(40000);
        num_errors++;
        $display("watchdog expired");
        results();
    end
endmodule // fpb_read_port_bench
